// File: hw/lbi_pkg.sv
// Purpose: Shared constants and carriers for the local bus control block
// Assumes: 125 MHz core clock, 20-bit address, 8-bit data bus
// Notes:   Reset values of all pin outputs except hlda live here
package lbi_pkg;
    localparam int          LBI_AW         = 20;
    localparam int          LBI_DW         = 8;
    localparam int          LBI_SYNC_DEPTH = 2;
    localparam logic        LBI_ALE_RST    = 1'b0;
    localparam logic        LBI_STROBE_RST = 1'b1;
    localparam logic        LBI_DIR_RST    = 1'b0;
    localparam logic        LBI_OE_N_RST   = 1'b1;
    localparam logic        LBI_CLKOUT_RST = 1'b0;
    localparam logic [LBI_DW-1:0] LBI_DATA_RST = 8'h00;
    localparam logic [LBI_AW-1:0] LBI_ADDR_RST = 20'h0_0000;

    typedef struct packed {
        logic [LBI_AW-1:0] addr;
        logic [LBI_DW-1:0] wdata;
        logic              write;
        logic              mem;
        logic              lock;
    } lbi_req_s;

    typedef enum logic [5:0] {
        LBI_IDLE = 6'b00_0001,
        LBI_T1   = 6'b00_0010,
        LBI_T2   = 6'b00_0100,
        LBI_TW   = 6'b00_1000,
        LBI_T4   = 6'b01_0000,
        LBI_HOLD = 6'b10_0000
    } lbi_state_e;
endpackage

// File: hw/lbi_ctrl.sv
// Purpose: Local bus cycle sequencer with hold/grant arbitration
// Assumes: One request at a time from the core; pins are asynchronous
// Notes:   All outputs registered; clk_en low freezes every flop
`timescale 1ns/1ps
// Overview of operation
// - Address strobe high during address phase
// - Clock output is half rate, 50% duty
// - Data enable low only during data transfer
// - Direction high transmit, low receive
// - Yield bus only at unlocked instruction boundary
// - Grant high once bus released
// - Float data and controls while granted
// - Lower select low for low memory addresses
// - No bus yield while lock is active
module lbi_ctrl
    import lbi_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire lbi_req_s          req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    output logic [LBI_DW-1:0]      rsp_rdata,
    output logic                   rsp_done,
    input  wire logic              instr_boundary,
    input  wire logic [LBI_AW-1:0] lcs_top,
    input  wire logic              ardy,
    input  wire logic              hold,
    output logic                   hlda,
    output logic                   clkout,
    output logic                   ale,
    output logic                   den_n,
    output logic                   buffer_direction,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   ctl_oe_n,
    output logic                   lock_n,
    output logic                   lcs_n,
    output logic [LBI_AW-1:0]      addr_out,
    output logic                   addr_oe_n,
    input  wire logic [LBI_DW-1:0] ad_in,
    output logic [LBI_DW-1:0]      ad_out,
    output logic                   ad_oe_n
);
    // Two-flop synchronisers; only the last stage is read
    logic [LBI_SYNC_DEPTH-1:0] ardy_sync_reg;
    logic [LBI_SYNC_DEPTH-1:0] hold_sync_reg;
    logic [LBI_DW-1:0]         data_sync_reg [LBI_SYNC_DEPTH];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ardy_sync_reg <= '0;
            hold_sync_reg <= '0;
        end else if (clk_en) begin
            ardy_sync_reg <= {ardy_sync_reg[0], ardy};
            hold_sync_reg <= {hold_sync_reg[0], hold};
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < LBI_SYNC_DEPTH; gi++) begin : g_dsync
            wire [LBI_DW-1:0] stage_d;
            // Head stage takes the pin; no stage indexes below zero
            if (gi == 0) begin : g_head
                assign stage_d = ad_in;
            end else begin : g_tail
                assign stage_d = data_sync_reg[gi-1];
            end
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    data_sync_reg[gi] <= LBI_DATA_RST;
                end else if (clk_en) begin
                    data_sync_reg[gi] <= stage_d;
                end
            end
        end
    endgenerate

    wire ardy_s = ardy_sync_reg[LBI_SYNC_DEPTH-1];
    wire hold_s = hold_sync_reg[LBI_SYNC_DEPTH-1];
    wire [LBI_DW-1:0] data_s = data_sync_reg[LBI_SYNC_DEPTH-1];

    lbi_state_e state_reg;
    lbi_state_e state_next;
    lbi_req_s   cur_reg;

    // Yield only between instructions, never under lock
    wire grant_ok = hold_s && instr_boundary && lock_n;
    wire start_ok = req_valid && !grant_ok;
    wire low_hit  = req.mem && (req.addr <= lcs_top);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LBI_IDLE: begin
                if (grant_ok) begin
                    state_next = LBI_HOLD;
                end else if (start_ok) begin
                    state_next = LBI_T1;
                end
            end
            LBI_T1:   state_next = LBI_T2;
            LBI_T2:   state_next = LBI_TW;
            LBI_TW: begin
                if (ardy_s) begin
                    state_next = LBI_T4;
                end
            end
            LBI_T4:   state_next = LBI_IDLE;
            LBI_HOLD: begin
                if (!hold_s) begin
                    state_next = LBI_IDLE;
                end
            end
            default:  state_next = LBI_IDLE;
        endcase
    end

    wire go_t1   = (state_reg == LBI_IDLE) && (state_next == LBI_T1);
    wire go_t2   = (state_reg == LBI_T1);
    wire go_t4   = (state_reg == LBI_TW) && ardy_s;
    wire go_hold = (state_reg == LBI_IDLE) && (state_next == LBI_HOLD);
    wire go_free = (state_reg == LBI_HOLD) && !hold_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LBI_IDLE;
            cur_reg   <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (go_t1) begin
                cur_reg <= req;
            end
        end
    end

    // Divide by two from core clock; flop output keeps duty at 50%
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkout <= LBI_CLKOUT_RST;
        end else if (clk_en) begin
            clkout <= !clkout;
        end
    end

    // Bus pin sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ale              <= LBI_ALE_RST;
            den_n            <= LBI_STROBE_RST;
            rd_n             <= LBI_STROBE_RST;
            wr_n             <= LBI_STROBE_RST;
            buffer_direction <= LBI_DIR_RST;
            lock_n           <= LBI_STROBE_RST;
            lcs_n            <= LBI_STROBE_RST;
            ctl_oe_n         <= LBI_OE_N_RST;
            addr_oe_n        <= LBI_OE_N_RST;
            ad_oe_n          <= LBI_OE_N_RST;
            addr_out         <= LBI_ADDR_RST;
            ad_out           <= LBI_DATA_RST;
            hlda             <= 1'b0;
            req_ready        <= 1'b0;
            rsp_done         <= 1'b0;
            rsp_rdata        <= LBI_DATA_RST;
        end else if (clk_en) begin
            ale       <= go_t1;
            rsp_done  <= go_t4;
            req_ready <= (state_next == LBI_IDLE) && !grant_ok;
            if (go_t1) begin
                addr_out         <= req.addr;
                ad_out           <= req.addr[LBI_DW-1:0];
                addr_oe_n        <= 1'b0;
                ad_oe_n          <= 1'b0;
                ctl_oe_n         <= 1'b0;
                buffer_direction <= req.write;
                lock_n           <= !req.lock;
                lcs_n            <= !low_hit;
            end
            if (go_t2) begin
                den_n   <= 1'b0;
                rd_n    <= cur_reg.write;
                wr_n    <= !cur_reg.write;
                ad_out  <= cur_reg.wdata;
                ad_oe_n <= !cur_reg.write;
            end
            if (go_t4) begin
                den_n     <= 1'b1;
                rd_n      <= 1'b1;
                wr_n      <= 1'b1;
                lcs_n     <= 1'b1;
                ad_oe_n   <= 1'b1;
                rsp_rdata <= data_s;
                // Lock spans a whole locked sequence, so keep it if asked
                if (!(req_valid && req.lock)) begin
                    lock_n <= 1'b1;
                end
            end
            if (go_hold) begin
                hlda      <= 1'b1;
                ctl_oe_n  <= 1'b1;
                addr_oe_n <= 1'b1;
                ad_oe_n   <= 1'b1;
            end
            if (go_free) begin
                hlda <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_ALE_PULSE: assert property (clk_en && go_t1 |=> ale && state_reg == LBI_T1)
        else $error("Address strobe missing in address phase");
    AST_WAIT_READY: assert property (state_reg == LBI_TW && !ardy_s |=> !rsp_done)
        else $error("Cycle finished without ready");
    AST_CLK_TOGGLE: assert property (clk_en |=> clkout != $past(clkout))
        else $error("Clock output did not toggle");
    AST_DEN_PHASE: assert property (
        !den_n |-> state_reg inside {LBI_T2, LBI_TW})
        else $error("Data enable outside data phase");
    AST_DIR_WRITE: assert property (!wr_n |-> buffer_direction)
        else $error("Direction not transmit on write");
    AST_DIR_READ: assert property (!rd_n |-> !buffer_direction)
        else $error("Direction not receive on read");
    AST_GRANT_SEQ: assert property (clk_en && go_hold |=> hlda ##0 ctl_oe_n ##0 ad_oe_n)
        else $error("Grant not given on release");
    AST_FLOAT: assert property (hlda |-> ctl_oe_n && addr_oe_n && ad_oe_n)
        else $error("Bus driven while granted");
    AST_LOCK_HOLD: assert property (!lock_n |=> !$rose(hlda))
        else $error("Bus granted while locked");
    AST_BOUNDARY: assert property ($rose(hlda) |-> $past(instr_boundary))
        else $error("Bus yielded off an instruction boundary");
    AST_LCS: assert property (!lcs_n |-> cur_reg.mem && cur_reg.addr <= lcs_top)
        else $error("Lower select on wrong address");
    // A one-flop path would let hold through a cycle early
    AST_SYNC: assert property (
        $rose(hold_s) && $past(clk_en) && $past(clk_en, 2)
        |-> $past(hold, 2))
        else $error("Hold synchroniser skipped stage");

    COV_READ:  cover property (go_t2 && !cur_reg.write ##[1:20] rsp_done);
    COV_WRITE: cover property (go_t2 && cur_reg.write ##[1:20] rsp_done);
    COV_HOLD:  cover property ($rose(hlda) ##[1:50] $fell(hlda));
endmodule

// File: dv/lbi_mem_model.sv
// Purpose: Memory and ready model on the far side of the local bus
// Assumes: Ready is paced by a slow link clock, unrelated to core_clk
// Notes:   Idle data lines show the inverse byte, never a stale match
`timescale 1ns/1ps
module lbi_mem_model
    import lbi_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              link_clk,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              ale,
    input  wire logic [LBI_AW-1:0] addr_out,
    input  wire logic [LBI_DW-1:0] ad_out,
    input  wire logic [3:0]        wait_cyc,
    output logic                   ardy,
    output logic [LBI_DW-1:0]      ad_in
);
    logic [LBI_DW-1:0] mem [256];
    logic [7:0]        line_sel = 8'h00;
    logic [3:0]        cnt = 4'h0;
    wire               idle = rd_n & wr_n;
    initial foreach (mem[i]) mem[i] = 8'h00;
    always @(posedge core_clk) begin
        if (ale === 1'b1) line_sel <= addr_out[7:0];
        if (wr_n === 1'b0) mem[line_sel] <= ad_out;
    end
    // Wait counter clears between strobes so each cycle starts slow
    always @(posedge link_clk or posedge idle) begin
        if (idle) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
    end
    // Ready only after the programmed wait
    assign ardy  = !idle && (cnt >= wait_cyc);
    assign ad_in = rd_n ? ~mem[line_sel] : mem[line_sel];
endmodule

// File: dv/lbi_ctrl_tb.sv
// Purpose: Self-checking bench for the local bus control block
// Assumes: Bench acts as core and as the alternate bus master
// Notes:   A monitor checks read data against a queue of notes
`timescale 1ns/1ps
module lbi_ctrl_tb
    import lbi_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    logic              instr_boundary = 1'b0;
    logic              hold = 1'b0;
    logic              prev_clk = 1'b0;
    logic              prev_rst = 1'b0;
    lbi_req_s          req = '0;
    logic [LBI_AW-1:0] lcs_top = 20'h0_0000;
    logic [LBI_AW-1:0] ad;
    logic [3:0]        wait_cyc = 4'h0;
    logic [LBI_DW-1:0] shadow [256];
    logic [LBI_DW:0]   notes [$];
    logic [LBI_DW:0]   note;
    int                n_errors = 0;
    int                total_checks = 0;
    int                cycles = 0;
    wire logic req_ready, rsp_done, hlda, clkout, ale, den_n, dir, rd_n, wr_n;
    wire logic ctl_oe_n, lock_n, lcs_n, addr_oe_n, ad_oe_n, ardy;
    wire logic [LBI_DW-1:0] rsp_rdata, ad_in, ad_out;
    wire logic [LBI_AW-1:0] addr_out;
    lbi_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .rsp_rdata(rsp_rdata), .rsp_done(rsp_done), .lcs_top(lcs_top),
        .instr_boundary(instr_boundary), .ardy(ardy), .hold(hold),
        .hlda(hlda), .clkout(clkout), .ale(ale), .den_n(den_n),
        .buffer_direction(dir), .rd_n(rd_n), .wr_n(wr_n), .lock_n(lock_n),
        .ctl_oe_n(ctl_oe_n), .lcs_n(lcs_n), .addr_out(addr_out),
        .addr_oe_n(addr_oe_n), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n));
    lbi_mem_model mem (.core_clk(core_clk), .link_clk(link_clk),
        .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .addr_out(addr_out),
        .ad_out(ad_out), .wait_cyc(wait_cyc), .ardy(ardy), .ad_in(ad_in));
    always #4 core_clk = ~core_clk;
    // Link clock stands still between strobes
    initial begin
        #37;
        forever #80 link_clk = (rd_n & wr_n) ? 1'b0 : ~link_clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic bus_cycle(logic wr, logic m, logic lk, logic keep);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        req = '{addr: ad, wdata: LBI_DW'($urandom()), write: wr, mem: m,
                lock: lk};
        lcs_top = $urandom_range(1) ? ad : ad - 20'h0_0001;
        wait_cyc = 4'($urandom_range(3));
        if (wr) shadow[ad[7:0]] = req.wdata;
        notes.push_back({!wr, shadow[ad[7:0]]});
        req_valid = 1'b1;
        step(1);
        // Keep asks again at once, with hold raised under the lock
        req_valid = keep;
        if (keep) hold = 1'b1;
        check("ale_t1", 8'h01, 8'(ale));
        check("addr_t1", ad[7:0], addr_out[7:0]);
        check("ad_t1", ad[7:0], ad_out);
        check("lcs_n", 8'(!(m && ad <= lcs_top)), 8'(lcs_n));
        check("dir", 8'(wr), 8'(dir));
        check("lock_n", 8'(!lk), 8'(lock_n));
        check("den_n_t1", 8'h01, 8'(den_n));
        step(1);
        check("den_n_t2", 8'h00, 8'(den_n));
        check("ale_t2", 8'h00, 8'(ale));
        check("strobes", {6'h00, wr, !wr}, {6'h00, rd_n, wr_n});
        check("ad_oe_n", 8'(!wr), 8'(ad_oe_n));
        if (wr) check("wdata", req.wdata, ad_out);
        n = 0;
        while (rsp_done !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        check("done_seen", 8'h01, 8'(rsp_done));
        step(1);
        check("den_n_end", 8'h01, 8'(den_n));
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
        if (prev_rst && rst_n)
            check("clkout", 8'(!prev_clk), 8'(clkout));
        prev_clk <= clkout;
        prev_rst <= rst_n;
        if (rsp_done === 1'b1) begin
            note = notes.pop_front();
            if (note[LBI_DW]) check("rdata", note[7:0], rsp_rdata);
            check("hlda_done", 8'h00, 8'(hlda));
        end
    end
    initial begin
        void'($urandom(80989));
        foreach (shadow[i]) shadow[i] = 8'h00;
        step(4);
        rst_n = 1'b1;
        step(2);
        for (int i = 0; i < 8; i++) begin
            ad = LBI_AW'($urandom());
            bus_cycle(1'b1, i[0], i[1], 1'b0);
            bus_cycle(1'b0, i[0], i[2], 1'b0);
        end
        hold = 1'b1;
        step(20);
        check("hlda_off_boundary", 8'h00, 8'(hlda));
        instr_boundary = 1'b1;
        step(6);
        check("hlda", 8'h01, 8'(hlda));
        check("float", 8'h07, 8'({ctl_oe_n, ad_oe_n, addr_oe_n}));
        check("ready_granted", 8'h00, 8'(req_ready));
        hold = 1'b0;
        step(6);
        check("hlda_release", 8'h00, 8'(hlda));
        // Locked write then read: the idle gap must not yield the bus
        ad = LBI_AW'($urandom());
        bus_cycle(1'b1, 1'b1, 1'b1, 1'b1);
        bus_cycle(1'b0, 1'b1, 1'b1, 1'b0);
        step(4);
        check("hlda_after_lock", 8'h01, 8'(hlda));
        hold = 1'b0;
        step(6);
        stop_test();
    end
endmodule
